// [logic/gp_counter_one.sv]
`timescale 1ns/1ps
`default_nettype none

// Fractional rate generator: one-cycle tick at OUT_KHZ on average
module rate_gen #(
  parameter int IN_KHZ  = 50000,
  parameter int OUT_KHZ = 20000
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  output logic      o_tick
);
  logic [16:0] acc;
  logic [17:0] sum;
  logic        wrap;

  // Sum checked against the input rate; uneven spacing when not integer
  assign sum  = {1'b0, acc} + 18'(OUT_KHZ);
  assign wrap = sum >= 18'(IN_KHZ);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc    <= 17'h00000;
      o_tick <= 1'b0;
    end else begin
      acc    <= wrap ? 17'(sum - 18'(IN_KHZ)) : sum[16:0];
      o_tick <= wrap;
    end
  end
endmodule

// Three-flop pin filter; value moves once stages two and three agree
module pin_filter #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1      <= '0;
      s2      <= '0;
      s3      <= '0;
      o_level <= '0;
    end else begin
      s1      <= i_pin;
      s2      <= s1;
      s3      <= s2;
      o_level <= (s2 & ~(s2 ^ s3)) | (o_level & (s2 ^ s3));
    end
  end
endmodule

module gp_counter_one
  import gpc_pkg::*;
#(
  parameter int NPIN  = 10,
  parameter int CNT_W = 24
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic [NPIN-1:0]   i_programmable_function_pin,
  input  wire logic              i_digital_line_seven,
  input  wire logic              i_digital_line_six,
  output logic                   o_counter_one_clock_out,
  output logic                   o_counter_one_clock_oe_n,
  output logic                   o_counter_one_gate_out,
  output logic                   o_counter_one_gate_oe_n,
  output logic                   o_counter_one_terminal_out,
  output logic                   o_counter_one_terminal_oe_n,
  output logic                   o_divided_clock_out,
  output logic                   o_divided_clock_oe_n,
  output logic                   o_gate_request,
  output logic                   o_digital_line_seven_free,
  output logic                   o_counter_zero_count_up
);

  ctrl_t            ctrl;
  freq_t            freq;
  logic [3:0]       clk_sel;
  logic [3:0]       gate_sel;
  logic [1:0]       dir0;
  logic [CNT_W-1:0] load_val;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] latched;
  logic [1:0]       sts;
  logic [NPIN-1:0]  pin_f;
  logic [1:0]       dir_f;
  logic             tick_fast;
  logic             tick_slow;
  logic             tick_freq;
  logic             clk_lvl_q;
  logic             gate_lvl_q;
  logic             gate_pend;
  logic             gate_run;
  logic             tc_pulse;
  logic             tc_tog;
  logic [3:0]       fcnt;
  logic             fpulse;

  // Timebases as enables; no derived clocks anywhere
  rate_gen #(.IN_KHZ(MCLK_KHZ), .OUT_KHZ(TB_FAST_KHZ)) u_tb_fast (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .o_tick (tick_fast)
  );
  rate_gen #(.IN_KHZ(MCLK_KHZ), .OUT_KHZ(TB_SLOW_KHZ)) u_tb_slow (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .o_tick (tick_slow)
  );
  rate_gen #(.IN_KHZ(MCLK_KHZ), .OUT_KHZ(TB_FREQ_KHZ)) u_tb_freq (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .o_tick (tick_freq)
  );

  // Pins come from outside; filtered before any edge logic
  pin_filter #(.W(NPIN)) u_pin_f (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_pin   (i_programmable_function_pin),
    .o_level (pin_f)
  );
  pin_filter #(.W(2)) u_dir_f (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_pin   ({i_digital_line_six, i_digital_line_seven}),
    .o_level (dir_f)
  );

  // Address decode
  wire wr_ctrl   = i_wr && (i_addr == OFS_CTRL);
  wire wr_pinsel = i_wr && (i_addr == OFS_PINSEL);
  wire wr_load   = i_wr && (i_addr == OFS_LOAD);
  wire wr_status = i_wr && (i_addr == OFS_STATUS);
  wire wr_freq   = i_wr && (i_addr == OFS_FREQ);
  wire wr_dir0   = i_wr && (i_addr == OFS_DIR0);

  // Source selection; a pin number past the last pin reads low
  wire clk_lvl    = (32'(clk_sel) < NPIN) ? pin_f[clk_sel] : 1'b0;
  wire gate_lvl   = (32'(gate_sel) < NPIN) ? pin_f[gate_sel] : 1'b0;
  wire clk_rise   = clk_lvl & ~clk_lvl_q;
  wire clk_fall_e = clk_lvl_q & ~clk_lvl;
  wire ext_edge   = ctrl.clk_fall ? clk_fall_e : clk_rise;
  wire int_tick   = ctrl.tb_slow ? tick_slow : tick_fast;
  wire src_tick   = ctrl.clk_ext ? ext_edge : int_tick;
  wire gate_edge  = ctrl.gate_fall ? (gate_lvl_q & ~gate_lvl)
                                   : (gate_lvl & ~gate_lvl_q);

  // Gate acts only on the active edge after it was seen
  wire gate_act   = src_tick & gate_pend;
  wire dir_up     = ctrl.dir_ext_en ? dir_f[0] : ctrl.dir_sw_up;
  wire gate_flip  = gate_act & (ctrl.gate_mode == GATE_STARTSTOP);
  wire cnt_en     = ctrl.run & ((ctrl.gate_mode != GATE_STARTSTOP) | (gate_run ^ gate_flip));
  wire at_end     = dir_up ? (&count) : (count == '0);
  wire tc         = src_tick & cnt_en & at_end;
  wire ftick      = freq.tb_slow ? tick_slow : tick_freq;

  // Counter next value; a load write wins over counting
  wire [CNT_W-1:0] next_count =
      wr_load                     ? i_wdata[CNT_W-1:0] :
      !(src_tick && cnt_en)       ? count :
      (at_end && ctrl.reload_en)  ? load_val :
      dir_up                      ? count + 1'b1 : count - 1'b1;

  // Sticky flags; a new event beats a same-cycle clear
  wire [1:0] sts_evt  = {tc, gate_act && (ctrl.gate_mode == GATE_EVENT)};
  wire [1:0] sts_clr  = wr_status ? i_wdata[STS_TC_BIT:STS_GATE_BIT] : 2'h0;
  wire [1:0] next_sts = (sts & ~sts_clr) | sts_evt;

  // Read mux; unmapped offsets read zero
  wire [DATA_W-1:0] rd_val =
      (i_addr == OFS_CTRL)   ? {16'h0000, ctrl} :
      (i_addr == OFS_PINSEL) ? {24'h000000, gate_sel, clk_sel} :
      (i_addr == OFS_LOAD)   ? DATA_W'(load_val) :
      (i_addr == OFS_COUNT)  ? DATA_W'(count) :
      (i_addr == OFS_LATCH)  ? DATA_W'(latched) :
      (i_addr == OFS_STATUS) ? {30'h00000000, sts} :
      (i_addr == OFS_FREQ)   ? {26'h0000000, freq} :
      (i_addr == OFS_DIR0)   ? {30'h00000000, dir0} : '0;

  // Output enables straight from control; all off after reset
  assign o_counter_one_clock_oe_n    = ~ctrl.clk_oe;
  assign o_counter_one_gate_oe_n     = ~ctrl.gate_oe;
  assign o_counter_one_terminal_oe_n = ~ctrl.tc_oe;
  assign o_divided_clock_oe_n        = ~ctrl.freq_oe;
  assign o_digital_line_seven_free   = ~ctrl.dir_ext_en;

  // Software registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl     <= ctrl_t'(CTRL_RST);
      freq     <= freq_t'(FREQ_RST);
      clk_sel  <= PINSEL_RST[PSEL_CLK_LSB +: 4];
      gate_sel <= PINSEL_RST[PSEL_GATE_LSB +: 4];
      dir0     <= DIR0_RST;
      load_val <= '0;
      o_rdata  <= '0;
    end else begin
      if (wr_ctrl) ctrl <= ctrl_t'(i_wdata[15:0]);
      if (wr_freq) freq <= freq_t'(i_wdata[5:0]);
      if (wr_pinsel) begin
        clk_sel  <= i_wdata[PSEL_CLK_LSB +: 4];
        gate_sel <= i_wdata[PSEL_GATE_LSB +: 4];
      end
      if (wr_dir0) dir0 <= i_wdata[DIR0_UP_BIT:DIR0_EXT_BIT];
      if (wr_load) load_val <= i_wdata[CNT_W-1:0];
      o_rdata <= i_rd ? rd_val : '0;
    end
  end

  // Counter, gate actions and flags
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      count          <= '0;
      latched        <= '0;
      sts            <= 2'h0;
      clk_lvl_q      <= 1'b0;
      gate_lvl_q     <= 1'b0;
      gate_pend      <= 1'b0;
      gate_run       <= 1'b0;
      o_gate_request <= 1'b0;
    end else begin
      count      <= next_count;
      sts        <= next_sts;
      clk_lvl_q  <= clk_lvl;
      gate_lvl_q <= gate_lvl;
      // Edge landing on the tick itself waits one more edge
      gate_pend  <= gate_edge | (gate_pend & ~src_tick);
      if (gate_act && ctrl.gate_mode == GATE_STARTSTOP) gate_run <= ~gate_run;
      if (gate_act && ctrl.gate_mode == GATE_LATCH) latched <= count;
      o_gate_request <= gate_act && (ctrl.gate_mode == GATE_EVENT);
    end
  end

  // Terminal output; state only moves on the active edge
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tc_pulse <= 1'b0;
      tc_tog   <= 1'b0;
      o_counter_one_terminal_out <= 1'b0;
    end else begin
      if (src_tick) tc_pulse <= tc;
      if (tc) tc_tog <= ~tc_tog;
      o_counter_one_terminal_out <= (ctrl.out_toggle ? tc_tog : tc_pulse)
                                    ^ ctrl.out_invert;
    end
  end

  // Mirrors of the clock and gate that the counter really uses, plus the count direction for counter zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_counter_one_clock_out <= 1'b0;
      o_counter_one_gate_out  <= 1'b0;
      o_counter_zero_count_up <= 1'b0;
    end else begin
      o_counter_one_clock_out <= ctrl.clk_ext ? clk_lvl : int_tick;
      o_counter_one_gate_out  <= gate_lvl;
      o_counter_zero_count_up <= dir0[DIR0_EXT_BIT] ? dir_f[1]
                                                    : dir0[DIR0_UP_BIT];
    end
  end

  // Divider: one input period high every div_m1+1 periods
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      fcnt   <= 4'h0;
      fpulse <= 1'b0;
      o_divided_clock_out <= 1'b0;
    end else begin
      if (ftick) begin
        fcnt   <= (fcnt == 4'h0) ? freq.div_m1 : fcnt - 4'h1;
        fpulse <= (fcnt == 4'h0);
      end
      o_divided_clock_out <= fpulse ^ freq.invert;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  AST_EXT_EDGE: assert property (
    ctrl.clk_ext && !ctrl.clk_fall && clk_rise |-> src_tick)
    else $error("external rising edge not counted");
  AST_CLK_MIRROR: assert property (
    ctrl.clk_ext ##1 ctrl.clk_ext |-> o_counter_one_clock_out == $past(clk_lvl))
    else $error("clock mirror differs from selected source");
  AST_INT_TB: assert property (
    !ctrl.clk_ext && !ctrl.tb_slow |-> src_tick == tick_fast)
    else $error("internal fast timebase not used");
  AST_GATE_LATCH: assert property (
    gate_act && ctrl.gate_mode == GATE_LATCH |=> latched == $past(count))
    else $error("gate did not latch count");
  AST_OE_OFF: assert property (
    !$past(wr_ctrl) |-> $stable({o_counter_one_clock_oe_n, o_counter_one_gate_oe_n,
                                 o_counter_one_terminal_oe_n, o_divided_clock_oe_n}))
    else $error("output enable moved without a control write");
  AST_PULSE_OUT: assert property (
    (tc && !ctrl.out_toggle) ##1 $stable(ctrl) ##1 $stable(ctrl)
    |-> o_counter_one_terminal_out == !ctrl.out_invert)
    else $error("terminal pulse missing");
  AST_DIR_DOWN: assert property (
    ctrl.dir_ext_en && !dir_f[0] && src_tick && cnt_en && !at_end && !wr_load
    |=> count == $past(count) - 1'b1)
    else $error("low direction did not count down");
  AST_TICK_ONLY: assert property (
    $changed(tc_pulse) |-> $past(src_tick))
    else $error("output state moved without clock edge");
  AST_GATE_TOGGLE: assert property (
    gate_act && ctrl.gate_mode == GATE_STARTSTOP |=> gate_run != $past(gate_run))
    else $error("gate did not start or stop");
  AST_FREQ_RELOAD: assert property (
    ftick && fcnt == 4'h0 && !wr_freq |=> fcnt == $past(freq.div_m1))
    else $error("divider reload wrong");
  AST_STS_SET_WINS: assert property (
    tc |=> sts[STS_TC_BIT])
    else $error("terminal flag lost");

  COV_TOGGLE_TC: cover property (tc && ctrl.out_toggle);
  COV_LATCH:     cover property (gate_act && ctrl.gate_mode == GATE_LATCH);
  COV_RELOAD:    cover property (tc && ctrl.reload_en);
  COV_FREQ:      cover property (fpulse && freq.div_m1 == 4'hF);

endmodule

`default_nettype wire

// [logic/gpc_pkg.sv]
package gpc_pkg;

  // Clock and timebase rates, in kHz
  localparam int MCLK_KHZ    = 50000;
  localparam int TB_FAST_KHZ = 20000;
  localparam int TB_SLOW_KHZ = 100;
  localparam int TB_FREQ_KHZ = 10000;

  // Register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PINSEL = 8'h04;
  localparam logic [7:0] OFS_LOAD   = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_LATCH  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FREQ   = 8'h18;
  localparam logic [7:0] OFS_DIR0   = 8'h1C;

  // Field positions of the loose registers
  localparam int PSEL_CLK_LSB  = 0;
  localparam int PSEL_GATE_LSB = 4;
  localparam int STS_GATE_BIT  = 0;
  localparam int STS_TC_BIT    = 1;
  localparam int DIR0_EXT_BIT  = 0;
  localparam int DIR0_UP_BIT   = 1;

  // What a gate edge does
  typedef enum logic [1:0] {
    GATE_NONE      = 2'b00,
    GATE_STARTSTOP = 2'b01,
    GATE_EVENT     = 2'b10,
    GATE_LATCH     = 2'b11
  } gate_mode_t;

  // Counter control word, bit 0 is clk_ext
  typedef struct packed {
    logic       freq_oe;
    logic       tc_oe;
    logic       gate_oe;
    logic       clk_oe;
    logic       run;
    logic       reload_en;
    logic       dir_sw_up;
    logic       dir_ext_en;
    logic       out_invert;
    logic       out_toggle;
    gate_mode_t gate_mode;
    logic       gate_fall;
    logic       clk_fall;
    logic       tb_slow;
    logic       clk_ext;
  } ctrl_t;

  // Divider control word
  typedef struct packed {
    logic       invert;
    logic       tb_slow;
    logic [3:0] div_m1;
  } freq_t;

  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [5:0]  FREQ_RST   = 6'h00;
  localparam logic [7:0]  PINSEL_RST = 8'h00;
  localparam logic [1:0]  DIR0_RST   = 2'h0;

endpackage

// [testbench/ext_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Far-side equipment; every level is held 8 mclk so the pin filter sees it
module ext_pin_model (
  input  wire logic       i_mclk,
  output logic      [9:0] o_pins,
  output logic            o_line_seven,
  output logic            o_line_six
);
  initial begin
    o_pins = 10'h000;
    o_line_seven = 1'b0;
    o_line_six = 1'b0;
  end

  // One pin change, then a hold longer than filter plus edge logic
  task automatic drive(input int idx, input logic v);
    @(posedge i_mclk);
    o_pins[idx] <= v;
    repeat (8) @(posedge i_mclk);
    #1;
  endtask

  // Whole clock pulse on one pin
  task automatic pulse(input int idx);
    drive(idx, 1'b1);
    drive(idx, 1'b0);
  endtask

  // Direction lines stay put until changed again
  task automatic set_dir(input logic seven, input logic six);
    @(posedge i_mclk);
    o_line_seven <= seven;
    o_line_six <= six;
    repeat (8) @(posedge i_mclk);
    #1;
  endtask
endmodule

`default_nettype wire

// [testbench/gp_counter_one_and_freq_divider_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module gp_counter_one_and_freq_divider_tb;
  import gpc_pkg::*;

  logic              mclk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [9:0]        pins;
  logic              seven;
  logic              six;
  logic              clk_out;
  logic              clk_oe_n;
  logic              gate_out;
  logic              gate_oe_n;
  logic              tc_out;
  logic              tc_oe_n;
  logic              div_out;
  logic              div_oe_n;
  logic              req;
  logic              free7;
  logic              up0;
  logic [31:0]       base;
  int                num_errors;
  int                num_checks;
  int                req_seen;

  gp_counter_one uut (
    .i_mclk(mclk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_programmable_function_pin(pins), .i_digital_line_seven(seven),
    .i_digital_line_six(six), .o_counter_one_clock_out(clk_out),
    .o_counter_one_clock_oe_n(clk_oe_n), .o_counter_one_gate_out(gate_out),
    .o_counter_one_gate_oe_n(gate_oe_n), .o_counter_one_terminal_out(tc_out),
    .o_counter_one_terminal_oe_n(tc_oe_n), .o_divided_clock_out(div_out),
    .o_divided_clock_oe_n(div_oe_n), .o_gate_request(req),
    .o_digital_line_seven_free(free7), .o_counter_zero_count_up(up0)
  );

  ext_pin_model pm (
    .i_mclk(mclk), .o_pins(pins), .o_line_seven(seven), .o_line_six(six)
  );

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Gate requests are one-cycle pulses, so count them as they pass
  always @(posedge mclk) if (rstn === 1'b1 && req === 1'b1) req_seen <= req_seen + 1;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Bus write; the #1 lets the register update land before any look
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // Bus read; data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    rd_reg(a, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic test_reset();
    settle();
    chk_pin(clk_oe_n, 1'b1, "clock oe_n");
    chk_pin(gate_oe_n, 1'b1, "gate oe_n");
    chk_pin(tc_oe_n, 1'b1, "terminal oe_n");
    chk_pin(div_oe_n, 1'b1, "divider oe_n");
    chk_reg(OFS_CTRL, 32'h0000_0000);
    wr_reg(OFS_COUNT, 32'h0000_0055);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    chk_reg(8'h40, 32'h0000_0000);
    $display("test_reset done");
  endtask

  // External clock on pin 2, pulse mode, both directions, rising then falling edge
  task automatic test_ext_count();
    wr_reg(OFS_PINSEL, 32'h0000_0052);
    wr_reg(OFS_CTRL, 32'h0000_7901);
    pm.set_dir(1'b1, 1'b0);
    wr_reg(OFS_LOAD, 32'h00FF_FFFE);
    pm.drive(2, 1'b1);
    chk_pin(clk_out, 1'b1, "clock mirror");
    pm.drive(2, 1'b0);
    chk_reg(OFS_COUNT, 32'h00FF_FFFF);
    chk_pin(tc_out, 1'b0, "no terminal yet");
    pm.pulse(2);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    chk_pin(tc_out, 1'b1, "terminal pulse");
    chk_reg(OFS_STATUS, 32'h0000_0002);
    wr_reg(OFS_STATUS, 32'h0000_0002);
    pm.pulse(2);
    chk_pin(tc_out, 1'b0, "pulse ends");
    chk_reg(OFS_STATUS, 32'h0000_0000);
    pm.set_dir(1'b0, 1'b0);
    pm.pulse(2);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    // Switching edge sense may itself look like an edge, so start from a fresh read
    wr_reg(OFS_CTRL, 32'h0000_7905);
    pm.set_dir(1'b1, 1'b0);
    rd_reg(OFS_COUNT, base);
    pm.drive(2, 1'b1);
    chk_reg(OFS_COUNT, base);
    pm.drive(2, 1'b0);
    chk_reg(OFS_COUNT, base + 32'h1);
    wr_reg(OFS_CTRL, 32'h0000_7805);
    chk_pin(free7, 1'b1, "line seven free");
    pm.pulse(2);
    chk_reg(OFS_COUNT, base);
    $display("test_ext_count done");
  endtask

  // Inverted pulse idle, then toggling on each terminal count
  task automatic test_toggle();
    logic t0;
    wr_reg(OFS_CTRL, 32'h0000_4881);
    wr_reg(OFS_LOAD, 32'h0000_0005);
    pm.pulse(2);
    chk_pin(tc_out, 1'b1, "inverted idle");
    chk_pin(clk_oe_n, 1'b1, "clock released");
    wr_reg(OFS_CTRL, 32'h0000_48C1);
    wr_reg(OFS_LOAD, 32'h0000_0000);
    t0 = tc_out;
    pm.pulse(2);
    chk_pin(tc_out, ~t0, "first toggle");
    wr_reg(OFS_LOAD, 32'h0000_0000);
    pm.pulse(2);
    chk_pin(tc_out, t0, "second toggle");
    $display("test_toggle done");
  endtask

  // Gate on pin 5: start/stop, then event request
  task automatic test_gate();
    wr_reg(OFS_CTRL, 32'h0000_2A11);
    wr_reg(OFS_LOAD, 32'h0000_0000);
    pm.pulse(2);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    pm.drive(5, 1'b1);
    chk_pin(gate_out, 1'b1, "gate mirror");
    chk_pin(gate_oe_n, 1'b0, "gate driven");
    pm.pulse(2);
    chk_reg(OFS_COUNT, 32'h0000_0001);
    wr_reg(OFS_CTRL, 32'h0000_2A21);
    wr_reg(OFS_STATUS, 32'h0000_0003);
    req_seen = 0;
    pm.drive(5, 1'b0);
    pm.drive(5, 1'b1);
    pm.pulse(2);
    chk_pin(req_seen == 1, 1'b1, "one gate request");
    chk_reg(OFS_STATUS, 32'h0000_0001);
    $display("test_gate done");
  endtask

  // Cycles to the next rising edge of the divider, and how many were high
  task automatic wait_rise(output int n, output int hi);
    logic prev;
    n = 0;
    hi = 1; // The rise seen just before the call is a high cycle too
    prev = 1'b1;
    while (n < 2500) begin
      @(posedge mclk);
      #1;
      n++;
      if (prev === 1'b0 && div_out === 1'b1) break;
      if (div_out === 1'b1) hi++;
      prev = div_out;
    end
    if (n >= 2500) begin
      num_errors++;
      $display("ERROR %0t: divider output never rose", $time);
      stop_test();
    end
  endtask

  task automatic test_divider();
    logic [3:0] dm [3] = '{4'hF, 4'h2, 4'h1};
    logic       slow [3] = '{1'b0, 1'b0, 1'b1};
    logic       inv [3] = '{1'b0, 1'b1, 1'b0};
    int         n;
    int         hi;
    int         p;
    wr_reg(OFS_CTRL, 32'h0000_8000);
    chk_pin(div_oe_n, 1'b0, "divider driven");
    for (int k = 0; k < 3; k++) begin
      p = slow[k] ? MCLK_KHZ / TB_SLOW_KHZ : MCLK_KHZ / TB_FREQ_KHZ;
      wr_reg(OFS_FREQ, {26'h0, inv[k], slow[k], dm[k]});
      // First two rises may still carry the old setting or an invert step
      wait_rise(n, hi);
      wait_rise(n, hi);
      wait_rise(n, hi);
      chk_pin(n == (int'(dm[k]) + 1) * p, 1'b1, "divider period");
      chk_pin(hi == (inv[k] ? int'(dm[k]) * p : p), 1'b1, "divider high time");
    end
    $display("test_divider done");
  endtask

  // Every pin as clock and gate source; both mirrors follow the chosen pin
  task automatic test_pins();
    pm.drive(5, 1'b0);
    wr_reg(OFS_CTRL, 32'h0000_3001);
    for (int i = 0; i < 10; i++) begin
      wr_reg(OFS_PINSEL, {24'h0, i[3:0], i[3:0]});
      pm.drive(i, 1'b1);
      chk_pin(clk_out, 1'b1, "clock mirror high");
      chk_pin(gate_out, 1'b1, "gate mirror high");
      pm.drive(i, 1'b0);
      chk_pin(clk_out, 1'b0, "clock mirror low");
      chk_pin(gate_out, 1'b0, "gate mirror low");
    end
    $display("test_pins done");
  endtask

  // Reload at terminal count, then a gate edge latching the count
  task automatic test_latch();
    wr_reg(OFS_PINSEL, 32'h0000_0052);
    // Idle edge clears a gate edge left over from the pin sweep
    wr_reg(OFS_CTRL, 32'h0000_0601);
    pm.pulse(2);
    wr_reg(OFS_LOAD, 32'h00FF_FFFE);
    wr_reg(OFS_CTRL, 32'h0000_0E31);
    pm.pulse(2);
    pm.pulse(2);
    chk_reg(OFS_COUNT, 32'h00FF_FFFE);
    pm.drive(5, 1'b1);
    pm.pulse(2);
    chk_reg(OFS_LATCH, 32'h00FF_FFFE);
    chk_reg(OFS_COUNT, 32'h00FF_FFFF);
    $display("test_latch done");
  endtask

  // Internal timebases: counts gathered over 1001 mclk edges
  task automatic test_internal();
    logic [31:0] got;
    int          lo;
    for (int k = 0; k < 2; k++) begin
      wr_reg(OFS_CTRL, (k == 0) ? 32'h0000_0A00 : 32'h0000_0A02);
      wr_reg(OFS_LOAD, 32'h0000_0000);
      repeat (1000) @(posedge mclk);
      rd_reg(OFS_COUNT, got);
      lo = 1001 * ((k == 0) ? TB_FAST_KHZ : TB_SLOW_KHZ) / MCLK_KHZ;
      chk_pin(int'(got) >= lo && int'(got) <= lo + 1, 1'b1, "internal count");
    end
    $display("test_internal done");
  endtask

  task automatic test_dir0();
    wr_reg(OFS_DIR0, 32'h0000_0001);
    pm.set_dir(1'b0, 1'b1);
    chk_pin(up0, 1'b1, "zero counts up");
    pm.set_dir(1'b0, 1'b0);
    chk_pin(up0, 1'b0, "zero counts down");
    wr_reg(OFS_DIR0, 32'h0000_0002);
    settle();
    chk_pin(up0, 1'b1, "zero software up");
    $display("test_dir0 done");
  endtask

  initial begin
    num_errors = 0;
    num_checks = 0;
    req_seen = 0;
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    test_reset();
    test_ext_count();
    test_toggle();
    test_gate();
    test_pins();
    test_latch();
    test_internal();
    test_divider();
    test_dir0();
    stop_test();
  end
endmodule

`default_nettype wire
